// [hdl/ext_op_params.svh]
// Purpose: named constants for the extended memory operation datapath
// Assumes: 8-bit data memory bytes and an 8-bit working register
// Notes:   definitions only
`ifndef EXT_OP_PARAMS_SVH
`define EXT_OP_PARAMS_SVH

`define BYTE_ZERO    8'h00
`define BYTE_ONES    8'hff
`define BYTE_ONE     8'h01
`define BIT_ONE      1'b1
`define BIT_ZERO     1'b0
`define MSB_POS      7
`define LSB_POS      0
`define NIB_LO_TOP   3
`define NIB_HI_BOT   4
`define WREG_RST     8'h00
`define FLAG_RST     1'b0

`endif

// [hdl/ext_op_pkg.sv]
// Purpose: types shared by the extended memory operation datapath
// Assumes: nothing beyond the constants header
// Notes:   opcode list covers the extended single-operand family only
package ext_op_pkg;

  typedef enum logic [4:0] {
    MOVE_WREG_TO_MEM                = 5'h00,
    OR_INTO_WREG                    = 5'h01,
    OR_INTO_MEM                     = 5'h02,
    ROTATE_LEFT_MEM                 = 5'h03,
    ROTATE_LEFT_TO_WREG             = 5'h04,
    ROTATE_LEFT_THRU_CARRY_MEM      = 5'h05,
    ROTATE_LEFT_THRU_CARRY_TO_WREG  = 5'h06,
    ROTATE_RIGHT_MEM                = 5'h07,
    ROTATE_RIGHT_TO_WREG            = 5'h08,
    ROTATE_RIGHT_THRU_CARRY_MEM     = 5'h09,
    ROTATE_RIGHT_THRU_CARRY_TO_WREG = 5'h0a,
    SUBTRACT_BORROW_TO_WREG         = 5'h0b,
    SUBTRACT_BORROW_TO_MEM          = 5'h0c,
    SUBTRACT_TO_WREG                = 5'h0d,
    SUBTRACT_TO_MEM                 = 5'h0e,
    DECREMENT_SKIP_ZERO             = 5'h0f,
    DECREMENT_SKIP_ZERO_TO_WREG     = 5'h10,
    INCREMENT_SKIP_ZERO             = 5'h11,
    INCREMENT_SKIP_ZERO_TO_WREG     = 5'h12,
    SET_ALL                         = 5'h13,
    SET_BIT                         = 5'h14,
    SKIP_IF_NONZERO_BYTE            = 5'h15,
    SKIP_IF_NONZERO_BIT             = 5'h16,
    NIBBLE_EXCHANGE                 = 5'h17
  } op_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_DUMMY = 2'b10
  } seq_state_t;

  typedef struct packed {
    seq_state_t fsm;
    logic [7:0] wreg;
    logic       carry;
    logic       nibble_carry_flag;
    logic       zero;
    logic       twos_complement_range_flag;
    logic       signed_compare_flag;
    logic       chained_zero_flag;
    logic       mem_we;
    logic [7:0] mem_wdata;
    logic       done;
    logic       skip_taken;
    logic       dummy_slot;
  } exec_state_t;

endpackage : ext_op_pkg

// [hdl/extended_memory_op_execute.sv]
// Purpose: execute stage for extended memory/working-register operations
// Assumes: mem_rdata holds the addressed byte in the cycle op_valid is high
// Notes:   a taken skip adds one dummy cycle in which new ops are refused
`timescale 1ns/100ps
`include "ext_op_params.svh"

module extended_memory_op_execute
  import ext_op_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // operation request
  input  wire logic       op_valid,
  input  wire op_t        op_code,
  input  wire logic [2:0] bit_sel,
  input  wire logic [7:0] mem_rdata,
  // working register and carry preset
  input  wire logic       preset_valid,
  input  wire logic [7:0] preset_wreg,
  input  wire logic       preset_carry,
  // memory write
  output logic            mem_we,
  output logic [7:0]      mem_wdata,
  // working register and flags
  output logic [7:0]      wreg,
  output logic            carry,
  output logic            nibble_carry_flag,
  output logic            zero,
  output logic            twos_complement_range_flag,
  output logic            signed_compare_flag,
  output logic            chained_zero_flag,
  // sequencer handshake
  output logic            done,
  output logic            skip_taken,
  output logic            dummy_slot
);

  exec_state_t st;
  exec_state_t next_st;

  logic       take;
  logic       borrow_in;
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic [7:0] sub_res;
  logic [7:0] dec_res;
  logic [7:0] inc_res;
  logic [7:0] bit_mask;

  // ****************************************************************
  // arithmetic helpers
  // ****************************************************************
  assign take      = op_valid && (st.fsm == ST_RUN);
  assign borrow_in = ((op_code == SUBTRACT_BORROW_TO_WREG) ||
                      (op_code == SUBTRACT_BORROW_TO_MEM)) ? ~st.carry : `BIT_ZERO;
  assign diff      = {1'b0, st.wreg} - {1'b0, mem_rdata} - {8'h00, borrow_in};
  assign low_diff  = {1'b0, st.wreg[`NIB_LO_TOP:`LSB_POS]}
                   - {1'b0, mem_rdata[`NIB_LO_TOP:`LSB_POS]} - {4'h0, borrow_in};
  assign sub_res   = diff[7:0];
  assign dec_res   = mem_rdata - `BYTE_ONE;
  assign inc_res   = mem_rdata + `BYTE_ONE;
  assign bit_mask  = `BYTE_ONE << bit_sel;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st            = st;
    next_st.mem_we     = `BIT_ZERO;
    next_st.done       = `BIT_ZERO;
    next_st.skip_taken = `BIT_ZERO;
    next_st.dummy_slot = `BIT_ZERO;
    next_st.fsm        = ST_RUN;
    case (st.fsm)
      ST_DUMMY: begin
        next_st.fsm = ST_RUN;
      end
      ST_RUN: begin
        if (preset_valid && !op_valid) begin
          next_st.wreg  = preset_wreg;
          next_st.carry = preset_carry;
        end
        if (take) begin
          next_st.done = `BIT_ONE;
          case (op_code)
            MOVE_WREG_TO_MEM: begin
              next_st.mem_we    = `BIT_ONE;
              next_st.mem_wdata = st.wreg;
            end
            OR_INTO_WREG: begin
              next_st.wreg = st.wreg | mem_rdata;
              next_st.zero = ((st.wreg | mem_rdata) == `BYTE_ZERO);
            end
            OR_INTO_MEM: begin
              next_st.mem_we    = `BIT_ONE;
              next_st.mem_wdata = st.wreg | mem_rdata;
              next_st.zero      = ((st.wreg | mem_rdata) == `BYTE_ZERO);
            end
            ROTATE_LEFT_MEM: begin
              next_st.mem_we    = `BIT_ONE;
              next_st.mem_wdata = {mem_rdata[6:0], mem_rdata[`MSB_POS]};
            end
            ROTATE_LEFT_TO_WREG: begin
              next_st.wreg = {mem_rdata[6:0], mem_rdata[`MSB_POS]};
            end
            ROTATE_LEFT_THRU_CARRY_MEM: begin
              next_st.mem_we    = `BIT_ONE;
              next_st.mem_wdata = {mem_rdata[6:0], st.carry};
              next_st.carry     = mem_rdata[`MSB_POS];
            end
            ROTATE_LEFT_THRU_CARRY_TO_WREG: begin
              next_st.wreg  = {mem_rdata[6:0], st.carry};
              next_st.carry = mem_rdata[`MSB_POS];
            end
            ROTATE_RIGHT_MEM: begin
              next_st.mem_we    = `BIT_ONE;
              next_st.mem_wdata = {mem_rdata[`LSB_POS], mem_rdata[7:1]};
            end
            ROTATE_RIGHT_TO_WREG: begin
              next_st.wreg = {mem_rdata[`LSB_POS], mem_rdata[7:1]};
            end
            ROTATE_RIGHT_THRU_CARRY_MEM: begin
              next_st.mem_we    = `BIT_ONE;
              next_st.mem_wdata = {st.carry, mem_rdata[7:1]};
              next_st.carry     = mem_rdata[`LSB_POS];
            end
            ROTATE_RIGHT_THRU_CARRY_TO_WREG: begin
              next_st.wreg  = {st.carry, mem_rdata[7:1]};
              next_st.carry = mem_rdata[`LSB_POS];
            end
            SUBTRACT_BORROW_TO_WREG, SUBTRACT_TO_WREG,
            SUBTRACT_BORROW_TO_MEM, SUBTRACT_TO_MEM: begin
              if ((op_code == SUBTRACT_BORROW_TO_MEM) || (op_code == SUBTRACT_TO_MEM)) begin
                next_st.mem_we    = `BIT_ONE;
                next_st.mem_wdata = sub_res;
              end else begin
                next_st.wreg = sub_res;
              end
              next_st.carry = ~diff[8];
              next_st.nibble_carry_flag = ~low_diff[4];
              next_st.zero = (sub_res == `BYTE_ZERO);
              next_st.twos_complement_range_flag =
                (st.wreg[`MSB_POS] != mem_rdata[`MSB_POS]) &&
                (sub_res[`MSB_POS] != st.wreg[`MSB_POS]);
              next_st.signed_compare_flag = sub_res[`MSB_POS] ^
                ((st.wreg[`MSB_POS] != mem_rdata[`MSB_POS]) &&
                 (sub_res[`MSB_POS] != st.wreg[`MSB_POS]));
              // chained zero keeps the earlier zero across a borrow chain
              if ((op_code == SUBTRACT_BORROW_TO_WREG) || (op_code == SUBTRACT_BORROW_TO_MEM)) begin
                next_st.chained_zero_flag = (sub_res == `BYTE_ZERO) && st.chained_zero_flag;
              end else begin
                next_st.chained_zero_flag = (sub_res == `BYTE_ZERO);
              end
            end
            DECREMENT_SKIP_ZERO: begin
              next_st.mem_we     = `BIT_ONE;
              next_st.mem_wdata  = dec_res;
              next_st.skip_taken = (dec_res == `BYTE_ZERO);
            end
            DECREMENT_SKIP_ZERO_TO_WREG: begin
              next_st.wreg       = dec_res;
              next_st.skip_taken = (dec_res == `BYTE_ZERO);
            end
            INCREMENT_SKIP_ZERO: begin
              next_st.mem_we     = `BIT_ONE;
              next_st.mem_wdata  = inc_res;
              next_st.skip_taken = (inc_res == `BYTE_ZERO);
            end
            INCREMENT_SKIP_ZERO_TO_WREG: begin
              next_st.wreg       = inc_res;
              next_st.skip_taken = (inc_res == `BYTE_ZERO);
            end
            SET_ALL: begin
              next_st.mem_we    = `BIT_ONE;
              next_st.mem_wdata = `BYTE_ONES;
            end
            SET_BIT: begin
              next_st.mem_we    = `BIT_ONE;
              next_st.mem_wdata = mem_rdata | bit_mask;
            end
            SKIP_IF_NONZERO_BYTE: begin
              next_st.skip_taken = (mem_rdata != `BYTE_ZERO);
            end
            SKIP_IF_NONZERO_BIT: begin
              next_st.skip_taken = ((mem_rdata & bit_mask) != `BYTE_ZERO);
            end
            NIBBLE_EXCHANGE: begin
              next_st.mem_we    = `BIT_ONE;
              next_st.mem_wdata = {mem_rdata[`NIB_LO_TOP:`LSB_POS],
                                   mem_rdata[`MSB_POS:`NIB_HI_BOT]};
            end
            default: begin
              next_st.done = `BIT_ZERO;
            end
          endcase
          if (next_st.skip_taken) begin
            next_st.fsm = ST_DUMMY;
          end
        end
      end
      default: begin
        next_st.fsm = ST_RUN;
      end
    endcase
    next_st.dummy_slot = (next_st.fsm == ST_DUMMY);
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '{fsm: ST_RUN, wreg: `WREG_RST, carry: `FLAG_RST,
              nibble_carry_flag: `FLAG_RST, zero: `FLAG_RST,
              twos_complement_range_flag: `FLAG_RST,
              signed_compare_flag: `FLAG_RST, chained_zero_flag: `FLAG_RST,
              mem_we: `BIT_ZERO, mem_wdata: `BYTE_ZERO, done: `BIT_ZERO,
              skip_taken: `BIT_ZERO, dummy_slot: `BIT_ZERO};
    end else begin
      st <= next_st;
    end
  end

  assign mem_we                     = st.mem_we;
  assign mem_wdata                  = st.mem_wdata;
  assign wreg                       = st.wreg;
  assign carry                      = st.carry;
  assign nibble_carry_flag          = st.nibble_carry_flag;
  assign zero                       = st.zero;
  assign twos_complement_range_flag = st.twos_complement_range_flag;
  assign signed_compare_flag        = st.signed_compare_flag;
  assign chained_zero_flag          = st.chained_zero_flag;
  assign done                       = st.done;
  assign skip_taken                 = st.skip_taken;
  assign dummy_slot                 = st.dummy_slot;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_MOVE_KEEPS_FLAGS: assert property (
    take && op_code == MOVE_WREG_TO_MEM |=> mem_we && mem_wdata == $past(wreg)
      && zero == $past(zero) && carry == $past(carry))
    else $error("move changed flags or wrote wrong data");
  AST_OR_ZERO: assert property (
    take && op_code == OR_INTO_WREG |=> wreg == ($past(wreg) | $past(mem_rdata))
      && zero == (wreg == `BYTE_ZERO) && carry == $past(carry))
    else $error("or result or zero flag wrong");
  AST_RL_MEM: assert property (
    take && op_code == ROTATE_LEFT_MEM |=> mem_we
      && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && $stable(carry))
    else $error("rotate left wrong");
  AST_RLC_WREG: assert property (
    take && op_code == ROTATE_LEFT_THRU_CARRY_TO_WREG |=> !mem_we
      && carry == $past(mem_rdata[7]) && wreg[0] == $past(carry))
    else $error("rotate left through carry to wreg wrong");
  AST_RRC_MEM: assert property (
    take && op_code == ROTATE_RIGHT_THRU_CARRY_MEM |=> mem_wdata[7] == $past(carry)
      && carry == $past(mem_rdata[0]))
    else $error("rotate right through carry wrong");
  AST_SUB_CARRY: assert property (
    take && op_code == SUBTRACT_TO_WREG |=> carry == ($past(wreg) >= $past(mem_rdata)))
    else $error("subtract carry not inverted borrow");
  AST_SBC_MEM: assert property (
    take && op_code == SUBTRACT_BORROW_TO_MEM |=> mem_we && $stable(wreg)
      && mem_wdata == 8'($past(wreg) - $past(mem_rdata) - {7'h00, ~$past(carry)}))
    else $error("subtract with borrow to memory wrong");
  AST_DEC_SKIP: assert property (
    take && op_code == DECREMENT_SKIP_ZERO && mem_rdata == `BYTE_ONE
      |=> skip_taken && dummy_slot && mem_we && mem_wdata == `BYTE_ZERO
      ##1 !dummy_slot && !done)
    else $error("decrement skip missing dummy cycle");
  AST_NO_SKIP_NONZERO: assert property (
    take && op_code == SKIP_IF_NONZERO_BYTE && mem_rdata == `BYTE_ZERO
      |=> done && !skip_taken && !dummy_slot)
    else $error("skip taken on zero byte");
  AST_DUMMY_REFUSES: assert property (
    dummy_slot |=> !done)
    else $error("op accepted during dummy cycle");
  AST_SKIP_PULSE: assert property (
    skip_taken |-> done && dummy_slot ##1 !skip_taken && !dummy_slot)
    else $error("skip without a single dummy cycle");
  AST_RR_WREG: assert property (
    take && op_code == ROTATE_RIGHT_TO_WREG |=> !mem_we && $stable(carry)
      && wreg == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
    else $error("rotate right to wreg wrong");
  AST_SUB_MEM_ZERO: assert property (
    take && op_code == SUBTRACT_TO_MEM |=> mem_we && $stable(wreg)
      && zero == (mem_wdata == `BYTE_ZERO) && chained_zero_flag == zero)
    else $error("subtract to memory zero flags wrong");
  AST_INC_WREG_SKIP: assert property (
    take && op_code == INCREMENT_SKIP_ZERO_TO_WREG |=> !mem_we && $stable(carry)
      && skip_taken == (wreg == `BYTE_ZERO))
    else $error("increment to wreg skip wrong");
  AST_SET_ALL: assert property (
    take && op_code == SET_ALL |=> mem_we && mem_wdata == `BYTE_ONES
      && $stable(carry) && $stable(zero))
    else $error("set byte wrong");
  AST_SET_BIT: assert property (
    take && op_code == SET_BIT |=> mem_we && mem_wdata[$past(bit_sel)]
      && $countones(mem_wdata ^ $past(mem_rdata)) <= 1)
    else $error("set bit touched other bits");
  AST_BIT_SKIP: assert property (
    take && op_code == SKIP_IF_NONZERO_BIT |=> !mem_we && $stable(wreg)
      && skip_taken == $past(mem_rdata[bit_sel]))
    else $error("bit skip decision wrong");
  AST_SWAP: assert property (
    take && op_code == NIBBLE_EXCHANGE |=> mem_we && $stable(zero)
      && mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
    else $error("nibble exchange wrong");

  COV_SKIP_INC: cover property (take && op_code == INCREMENT_SKIP_ZERO ##1 skip_taken);
  COV_SBC: cover property (take && op_code == SUBTRACT_BORROW_TO_WREG ##1 !carry);
  COV_SET_BIT: cover property (take && op_code == SET_BIT ##1 mem_we);
  COV_BACK_TO_BACK: cover property (done ##1 done);
  COV_BIT_SKIP: cover property (take && op_code == SKIP_IF_NONZERO_BIT ##1 skip_taken);

endmodule : extended_memory_op_execute

// [test/mem_seq_model.sv]
// Purpose: data memory and sequencer side of the extended op datapath
// Assumes: the byte address is presented together with op_valid
// Notes:   a pending write is forwarded to a read of the same byte
`timescale 1ns/100ps

module mem_seq_model (
  // clock
  input  wire logic       ref_clk,
  // read side
  input  wire logic       rd_en,
  input  wire logic [1:0] addr,
  output logic [7:0]      mem_rdata,
  // write side
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_wdata
);
  logic [7:0] mem [4];
  logic [1:0] addr_q;
  logic [7:0] last_rd;

  initial begin
    for (int i = 0; i < 4; i++) begin
      mem[i] = 8'h00;
    end
    addr_q  = 2'h0;
    last_rd = 8'h00;
  end

  // not read: inverse of the last value, so no stale byte looks valid
  always_comb begin
    if (!rd_en) begin
      mem_rdata = ~last_rd;
    end else if (mem_we && addr_q == addr) begin
      mem_rdata = mem_wdata;
    end else begin
      mem_rdata = mem[addr];
    end
  end

  // the write strobe trails the op by one cycle, so it uses the op's address
  always @(posedge ref_clk) begin
    last_rd <= mem_rdata;
    if (rd_en) begin
      addr_q <= addr;
    end
    if (mem_we) begin
      mem[addr_q] <= mem_wdata;
    end
  end
endmodule : mem_seq_model

// [test/tb.sv]
// Purpose: self-checking bench for the extended memory op datapath
// Assumes: one op per cycle, a taken skip adds one refused cycle
// Notes:   random ops from a fixed seed, with hand-picked skip corners and one subtract corner
`timescale 1ns/100ps

module tb
  import ext_op_pkg::*;
;
  localparam int TIMEOUT = 20000;
  logic       ref_clk, rst, op_valid, preset_valid, preset_carry;
  op_t        op_code;
  logic [2:0] bit_sel;
  logic [1:0] addr;
  logic [7:0] mem_rdata, preset_wreg, mem_wdata, wreg;
  logic       mem_we, carry, nibble_carry_flag, zero, twos_complement_range_flag;
  logic       signed_compare_flag, chained_zero_flag, done, skip_taken, dummy_slot;
  logic [7:0] shadow [4];
  logic [7:0] e_w, e_wd;
  logic       e_c, e_ac, e_z, e_ov, e_sc, e_cz, e_we, e_skip;
  int         failures, checks, cycles;
  logic [7:0] corner_w [9] = '{8'h01, 8'hff, 8'h00, 8'h01, 8'hff, 8'h80, 8'h7f, 8'h00, 8'h80};
  op_t        corner_op [9] = '{DECREMENT_SKIP_ZERO, INCREMENT_SKIP_ZERO, SKIP_IF_NONZERO_BYTE,
    DECREMENT_SKIP_ZERO_TO_WREG, INCREMENT_SKIP_ZERO_TO_WREG, SKIP_IF_NONZERO_BIT,
    SKIP_IF_NONZERO_BIT, DECREMENT_SKIP_ZERO, SUBTRACT_BORROW_TO_MEM};

  extended_memory_op_execute extended_memory_op_execute_i (
    .ref_clk(ref_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .bit_sel(bit_sel), .mem_rdata(mem_rdata), .preset_valid(preset_valid),
    .preset_wreg(preset_wreg), .preset_carry(preset_carry), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .wreg(wreg), .carry(carry), .nibble_carry_flag(nibble_carry_flag),
    .zero(zero), .twos_complement_range_flag(twos_complement_range_flag),
    .signed_compare_flag(signed_compare_flag), .chained_zero_flag(chained_zero_flag),
    .done(done), .skip_taken(skip_taken), .dummy_slot(dummy_slot));

  mem_seq_model mem_seq_model_i (
    .ref_clk(ref_clk), .rd_en(op_valid), .addr(addr), .mem_rdata(mem_rdata),
    .mem_we(mem_we), .mem_wdata(mem_wdata));

  // ****************************************
  // expected result of one op
  // ****************************************
  function automatic void predict(input op_t op, input logic [7:0] m, input logic [2:0] bs);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] r;
    logic       sb;
    sb     = (op == SUBTRACT_BORROW_TO_WREG || op == SUBTRACT_BORROW_TO_MEM);
    d      = {1'b0, e_w} - {1'b0, m} - 9'(sb & ~e_c);
    h      = {1'b0, e_w[3:0]} - {1'b0, m[3:0]} - 5'(sb & ~e_c);
    r      = m;
    e_skip = 1'b0;
    case (op)
      MOVE_WREG_TO_MEM: r = e_w;
      OR_INTO_WREG, OR_INTO_MEM: begin
        r   = e_w | m;
        e_z = (r == 8'h00);
      end
      ROTATE_LEFT_MEM, ROTATE_LEFT_TO_WREG: r = {m[6:0], m[7]};
      ROTATE_LEFT_THRU_CARRY_MEM, ROTATE_LEFT_THRU_CARRY_TO_WREG: begin
        r   = {m[6:0], e_c};
        e_c = m[7];
      end
      ROTATE_RIGHT_MEM, ROTATE_RIGHT_TO_WREG: r = {m[0], m[7:1]};
      ROTATE_RIGHT_THRU_CARRY_MEM, ROTATE_RIGHT_THRU_CARRY_TO_WREG: begin
        r   = {e_c, m[7:1]};
        e_c = m[0];
      end
      SUBTRACT_BORROW_TO_WREG, SUBTRACT_BORROW_TO_MEM, SUBTRACT_TO_WREG, SUBTRACT_TO_MEM: begin
        r    = d[7:0];
        e_c  = ~d[8];
        e_ac = ~h[4];
        e_ov = (e_w[7] != m[7]) && (r[7] != e_w[7]);
        e_sc = e_ov ^ r[7];
        e_z  = (r == 8'h00);
        e_cz = e_z & (sb ? e_cz : 1'b1);
      end
      DECREMENT_SKIP_ZERO, DECREMENT_SKIP_ZERO_TO_WREG: begin
        r      = m - 8'h01;
        e_skip = (r == 8'h00);
      end
      INCREMENT_SKIP_ZERO, INCREMENT_SKIP_ZERO_TO_WREG: begin
        r      = m + 8'h01;
        e_skip = (r == 8'h00);
      end
      SET_ALL: r = 8'hff;
      SET_BIT: r = m | (8'h01 << bs);
      SKIP_IF_NONZERO_BYTE: e_skip = (m != 8'h00);
      SKIP_IF_NONZERO_BIT: e_skip = m[bs];
      NIBBLE_EXCHANGE: r = {m[3:0], m[7:4]};
      default: r = m;
    endcase
    e_wd = r;
    e_we = !(op inside {SKIP_IF_NONZERO_BYTE, SKIP_IF_NONZERO_BIT, OR_INTO_WREG,
      ROTATE_LEFT_TO_WREG, ROTATE_LEFT_THRU_CARRY_TO_WREG, ROTATE_RIGHT_TO_WREG,
      ROTATE_RIGHT_THRU_CARRY_TO_WREG, SUBTRACT_BORROW_TO_WREG, SUBTRACT_TO_WREG,
      DECREMENT_SKIP_ZERO_TO_WREG, INCREMENT_SKIP_ZERO_TO_WREG});
    if (!e_we && !(op inside {SKIP_IF_NONZERO_BYTE, SKIP_IF_NONZERO_BIT})) begin
      e_w = r;
    end
  endfunction : predict

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      failures++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : check

  task automatic do_preset(input logic [7:0] w, input logic c);
    op_valid     = 1'b0;
    preset_valid = 1'b1;
    preset_wreg  = w;
    preset_carry = c;
    e_w          = w;
    e_c          = c;
    @(negedge ref_clk);
  endtask : do_preset

  // op held until the next edge; preset noise beside it must be ignored
  task automatic do_op(input op_t op, input logic [1:0] a, input logic [2:0] bs);
    op_valid     = 1'b1;
    op_code      = op;
    addr         = a;
    bit_sel      = bs;
    preset_valid = 1'($urandom);
    preset_wreg  = 8'($urandom);
    preset_carry = 1'($urandom);
    predict(op, shadow[a], bs);
    if (e_we) begin
      shadow[a] = e_wd;
    end
    @(negedge ref_clk);
    check({31'h0, done}, 32'h1);
    check({31'h0, mem_we}, {31'h0, e_we});
    if (e_we) begin
      check({24'h0, mem_wdata}, {24'h0, e_wd});
    end
    check({24'h0, wreg}, {24'h0, e_w});
    check({26'h0, carry, nibble_carry_flag, zero, twos_complement_range_flag,
      signed_compare_flag, chained_zero_flag}, {26'h0, e_c, e_ac, e_z, e_ov, e_sc, e_cz});
    check({30'h0, skip_taken, dummy_slot}, {30'h0, e_skip, e_skip});
    if (e_skip) begin
      op_code = op_t'(5'($urandom_range(23)));
      addr    = 2'($urandom);
      @(negedge ref_clk);
      check({29'h0, done, mem_we, dummy_slot}, 32'h0);
      check({24'h0, wreg}, {24'h0, e_w});
    end
  endtask : do_op

  task automatic finish_test();
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // ****************************************
  // clock, timeout and main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    cycles = 0;
    forever @(posedge ref_clk) begin
      cycles++;
      if (cycles >= TIMEOUT) begin
        failures++;
        finish_test();
      end
    end
  end

  initial begin
    {rst, op_valid, preset_valid, preset_carry} = 4'hf;
    {op_valid, preset_valid} = 2'h0;
    op_code     = MOVE_WREG_TO_MEM;
    bit_sel     = 3'h0;
    addr        = 2'h0;
    preset_wreg = 8'h00;
    {e_w, e_c, e_ac, e_z, e_ov, e_sc, e_cz} = 14'h0;
    failures    = 0;
    checks      = 0;
    for (int i = 0; i < 4; i++) begin
      shadow[i] = 8'h00;
    end
    void'($urandom(32'h2f3c4946));
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    check({20'h0, wreg, done, mem_we, skip_taken, dummy_slot}, 32'h0);
    // skip corners and one subtract-with-borrow corner: load the byte by a move, then operate on it
    for (int i = 0; i < 9; i++) begin
      do_preset(corner_w[i], 1'b1);
      do_op(MOVE_WREG_TO_MEM, 2'h0, 3'h0);
      do_op(corner_op[i], 2'h0, 3'h7);
    end
    // every opcode once in order, then a random stream
    for (int k = 0; k < 624; k++) begin
      if ($urandom_range(3) == 0) begin
        do_preset(8'($urandom), 1'($urandom));
      end
      do_op(op_t'(5'(k < 24 ? k : $urandom_range(23))), 2'($urandom), 3'($urandom));
    end
    op_valid = 1'b0;
    @(negedge ref_clk);
    finish_test();
  end
endmodule : tb
